// File: core/pspm_pkg.sv
// Constants for the power-on strap pin multiplexer
package pspm_pkg;
  // Strap register field positions
  localparam int unsigned STRAP_W            = 5;
  localparam int unsigned BIT_CONFIG_ADDRESS = 0;
  localparam int unsigned BIT_INFRARED_IDE   = 1;
  localparam int unsigned BIT_PNP_COMPAT     = 2;
  localparam int unsigned BIT_GAMEPORT_DMA   = 3;
  localparam int unsigned BIT_IRQ_GPIO       = 4;
  // Value after reset, equal to the pull defaults
  localparam logic [4:0]  STRAP_RESET        = 5'h0e;
  // Bit of the handshake status word that carries clear-to-send
  localparam int unsigned HS_CTS_BIT         = 4;
  localparam int unsigned HS_W               = 8;
  localparam logic [7:0]  HS_RESET           = 8'h00;
  localparam int unsigned SYNC_STAGES        = 2;
endpackage : pspm_pkg

// File: core/pspm_sync.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module pspm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    meta_reg <= meta_next;
    q_reg    <= q_next;
  end

  assign q = q_reg;
endmodule : pspm_sync

// File: core/pspm_strap_mux.sv
// Strap capture, pin function mux and host control pin handling
`timescale 1ns/1ps
module pspm_strap_mux (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       master_reset_in,
  // Strap pins sensed during reset (inputs of the two-way pins)
  input  wire logic       serial_out_a_in,
  input  wire logic       serial_out_b_in,
  input  wire logic       terminal_ready_a_n_in,
  input  wire logic       send_request_a_n_in,
  input  wire logic       send_request_b_n_in,
  // UART core side
  input  wire logic       uart_tx_a,
  input  wire logic       uart_tx_b,
  input  wire logic       uart_dtr_a,
  input  wire logic       uart_dtr_b,
  input  wire logic       uart_rts_a,
  input  wire logic       uart_rts_b,
  // Serial outputs with enables, except terminal_ready_b_n which is always driven
  output logic            serial_out_a,
  output logic            serial_out_a_oe,
  output logic            serial_out_b,
  output logic            serial_out_b_oe,
  output logic            terminal_ready_a_n,
  output logic            terminal_ready_a_n_oe,
  output logic            terminal_ready_b_n,
  output logic            send_request_a_n,
  output logic            send_request_a_n_oe,
  output logic            send_request_b_n,
  output logic            send_request_b_n_oe,
  // Modem inputs, active low
  input  wire logic       clear_to_send_a_n,
  input  wire logic       data_set_ready_a_n,
  input  wire logic       carrier_detect_a_n,
  input  wire logic       ring_indicator_a_n,
  output logic [7:0]      handshake_status_a,
  // Software write of the strap register
  input  wire logic       strap_wr,
  input  wire logic [4:0] strap_wdata,
  output logic [4:0]      strap_config_register,
  // Interrupt / GPIO shared pins
  input  wire logic       irq_a_src,
  input  wire logic       irq_b_src,
  input  wire logic [1:0] gpio_out,
  input  wire logic [1:0] gpio_oe,
  input  wire logic       gp_io_one_in,
  input  wire logic       gp_io_zero_in,
  output logic            gp_io_one,
  output logic            gp_io_one_oe,
  output logic            gp_io_zero,
  output logic            gp_io_zero_oe,
  output logic [1:0]      gpio_in,
  // Game port / DMA A pins
  input  wire logic       game_rd_n,
  input  wire logic       game_wr_n,
  input  wire logic       dma_a_req,
  input  wire logic       game_ack_n_in,
  output logic            game_pin_rd,
  output logic            game_pin_wr,
  output logic            dma_a_ack,
  // Host bus control
  input  wire logic       chip_select_n,
  input  wire logic       io_cycle_n,
  output logic            host_select,
  input  wire logic       epp_mode,
  input  wire logic       epp_busy,
  output logic            channel_ready_oe,
  input  wire logic       dma_active,
  input  wire logic       terminal_count,
  output logic            dma_done
);
  // Strap, master reset, host cycle, terminal count, acknowledge, modem and general I/O pin levels cross two flops first
  localparam int unsigned NS = 16;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  assign raw_in = {master_reset_in, serial_out_a_in, serial_out_b_in, terminal_ready_a_n_in,
                   send_request_a_n_in, send_request_b_n_in, chip_select_n, io_cycle_n,
                   terminal_count, game_ack_n_in, clear_to_send_a_n, data_set_ready_a_n,
                   carrier_detect_a_n, ring_indicator_a_n, gp_io_one_in, gp_io_zero_in};

  pspm_sync #(.W(NS)) u_sync (
    .ref_clk (ref_clk),
    .d       (raw_in),
    .q       (syn)
  );

  logic mr_s, serial_out_a_s, serial_out_b_s, dtra_s, rtsa_s, rtsb_s, cs_n_s, cyc_n_s, tc_s, ack_n_s;
  logic cts_s, dsr_s, dcd_s, ri_s, gp1_s, gp0_s;
  assign {mr_s, serial_out_a_s, serial_out_b_s, dtra_s, rtsa_s, rtsb_s, cs_n_s, cyc_n_s, tc_s, ack_n_s,
          cts_s, dsr_s, dcd_s, ri_s, gp1_s, gp0_s} = syn;

  logic [4:0] strap_reg,  strap_next;
  logic       mr_reg,     mr_next;
  logic [7:0] hs_reg,     hs_next;
  logic       sel_reg,    sel_next;
  logic       rdy_reg,    rdy_next;
  logic       done_reg,   done_next;
  logic [10:0] pin_reg,   pin_next;
  logic [1:0] gin_reg,    gin_next;
  logic       mr_fall;

  assign mr_fall = mr_reg & ~mr_s;

  always_comb begin
    strap_next = strap_reg;
    if (mr_fall) begin
      strap_next[pspm_pkg::BIT_INFRARED_IDE]   = serial_out_a_s;
      strap_next[pspm_pkg::BIT_GAMEPORT_DMA]   = serial_out_b_s;
      strap_next[pspm_pkg::BIT_CONFIG_ADDRESS] = dtra_s;
      strap_next[pspm_pkg::BIT_PNP_COMPAT]     = rtsa_s;
      strap_next[pspm_pkg::BIT_IRQ_GPIO]       = rtsb_s;
    end else if (strap_wr && !mr_s) begin
      strap_next = strap_wdata;
    end
    mr_next = mr_s;
    hs_next = {~ri_s, ~dcd_s, ~dsr_s,
               ~cts_s, 4'h0};
    sel_next  = ~cs_n_s & ~cyc_n_s;
    rdy_next  = epp_mode & sel_next & epp_busy;
    done_next = dma_active & tc_s;
    // Pin drivers: {serial_out_a,serial_out_b,dtra,dtrb,rtsa,rtsb,irqa/gp_io_one,oe1,irqb/gp_io_zero,oe0,drive}
    pin_next[10] = uart_tx_a;
    pin_next[9]  = uart_tx_b;
    pin_next[8]  = ~uart_dtr_a;
    pin_next[7]  = ~uart_dtr_b;
    pin_next[6]  = ~uart_rts_a;
    pin_next[5]  = ~uart_rts_b;
    if (strap_reg[pspm_pkg::BIT_IRQ_GPIO]) begin
      pin_next[4:1] = {gpio_out[1], gpio_oe[1], gpio_out[0], gpio_oe[0]};
    end else begin
      pin_next[4:1] = {irq_a_src, 1'b1, irq_b_src, 1'b1};
    end
    pin_next[0] = ~mr_s; // Pins float while straps are sensed
    gin_next = {gp1_s, gp0_s};
    if (mr_s) begin
      hs_next   = pspm_pkg::HS_RESET;
      sel_next  = 1'b0;
      rdy_next  = 1'b0;
      done_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_reg <= pspm_pkg::STRAP_RESET;
      mr_reg    <= 1'b1;
      hs_reg    <= pspm_pkg::HS_RESET;
      sel_reg   <= 1'b0;
      rdy_reg   <= 1'b0;
      done_reg  <= 1'b0;
      pin_reg   <= 11'h000;
      gin_reg   <= 2'h0;
    end else begin
      strap_reg <= strap_next;
      mr_reg    <= mr_next;
      hs_reg    <= hs_next;
      sel_reg   <= sel_next;
      rdy_reg   <= rdy_next;
      done_reg  <= done_next;
      pin_reg   <= pin_next;
      gin_reg   <= gin_next;
    end
  end

  // Game-port pins carry DMA A when strap bit 3 is low
  logic gp_rd_reg, gp_rd_next, gp_wr_reg, gp_wr_next, ack_reg, ack_next;
  always_comb begin
    if (strap_reg[pspm_pkg::BIT_GAMEPORT_DMA]) begin
      gp_rd_next = game_rd_n;
      gp_wr_next = game_wr_n;
      ack_next   = 1'b0;
    end else begin
      gp_rd_next = 1'b1;
      gp_wr_next = dma_a_req;
      ack_next   = ~ack_n_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gp_rd_reg <= 1'b1;
      gp_wr_reg <= 1'b1;
      ack_reg   <= 1'b0;
    end else begin
      gp_rd_reg <= gp_rd_next;
      gp_wr_reg <= gp_wr_next;
      ack_reg   <= ack_next;
    end
  end

  assign serial_out_a          = pin_reg[10];
  assign serial_out_b          = pin_reg[9];
  assign terminal_ready_a_n    = pin_reg[8];
  assign terminal_ready_b_n    = pin_reg[7];
  assign send_request_a_n      = pin_reg[6];
  assign send_request_b_n      = pin_reg[5];
  assign serial_out_a_oe       = pin_reg[0];
  assign serial_out_b_oe       = pin_reg[0];
  assign terminal_ready_a_n_oe = pin_reg[0];
  assign send_request_a_n_oe   = pin_reg[0];
  assign send_request_b_n_oe   = pin_reg[0];
  assign gp_io_one             = pin_reg[4];
  assign gp_io_one_oe          = pin_reg[3];
  assign gp_io_zero            = pin_reg[2];
  assign gp_io_zero_oe         = pin_reg[1];
  assign gpio_in               = gin_reg;
  assign handshake_status_a    = hs_reg;
  assign strap_config_register = strap_reg;
  assign host_select           = sel_reg;
  assign channel_ready_oe      = rdy_reg;
  assign dma_done              = done_reg;
  assign game_pin_rd           = gp_rd_reg;
  assign game_pin_wr           = gp_wr_reg;
  assign dma_a_ack             = ack_reg;

  // Assertions
  sequence mr_release_s;
    mr_reg && !mr_s;
  endsequence

  strap_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    mr_release_s |=> strap_reg[4] == $past(rtsb_s)) else $error("irq strap not captured");
  strap_ir_a: assert property (@(posedge ref_clk) disable iff (rst)
    mr_release_s |=> strap_reg[1] == $past(serial_out_a_s)) else $error("ir strap not captured");
  strap_gm_a: assert property (@(posedge ref_clk) disable iff (rst)
    mr_release_s |=> strap_reg[3] == $past(serial_out_b_s)) else $error("game strap not captured");
  strap_cfg_a: assert property (@(posedge ref_clk) disable iff (rst)
    mr_release_s |=> strap_reg[0] == $past(dtra_s)) else $error("cfg strap not captured");
  strap_pnp_a: assert property (@(posedge ref_clk) disable iff (rst)
    mr_release_s |=> strap_reg[2] == $past(rtsa_s)) else $error("pnp strap not captured");
  pin_mux_a: assert property (@(posedge ref_clk) disable iff (rst)
    !strap_reg[4] && !mr_s |=> gp_io_one_oe && gp_io_one == $past(irq_a_src))
    else $error("irq pin mux wrong");
  cts_status_a: assert property (@(posedge ref_clk) disable iff (rst)
    !mr_s |=> handshake_status_a[4] == !$past(cts_s)) else $error("cts bit wrong");
  mr_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    mr_s |=> !host_select && !dma_done) else $error("active during master reset");
  ready_a: assert property (@(posedge ref_clk) disable iff (rst)
    channel_ready_oe |-> $past(epp_mode) && $past(epp_busy)) else $error("ready stretch wrong");
  tc_end_a: assert property (@(posedge ref_clk) disable iff (rst)
    dma_active && tc_s && !mr_s |=> dma_done) else $error("tc missed");
  dtr_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    uart_dtr_b |=> !terminal_ready_b_n) else $error("dtr not low");
  rts_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    uart_rts_a |=> !send_request_a_n) else $error("rts not low");
  dsr_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    !mr_s && !dsr_s |=> handshake_status_a[5]) else $error("dsr polarity");
  game_dma_a: assert property (@(posedge ref_clk) disable iff (rst)
    !strap_reg[3] |=> game_pin_wr == $past(dma_a_req)) else $error("dma A mux wrong");
  strap_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    strap_wr && !mr_s && !mr_reg |=> strap_config_register == $past(strap_wdata))
    else $error("strap write lost");
endmodule : pspm_strap_mux

// File: dv/pspm_far_side.sv
// Far-side model: strap resistors on the serial pins and the shared I/O pins
`timescale 1ns/1ps
module pspm_far_side (
  input  wire logic [4:0] strap_drv,
  input  wire logic [4:0] strap_oe,
  input  wire logic [4:0] fitted,
  output logic      [4:0] strap_pin,
  input  wire logic [1:0] gp_drv,
  input  wire logic [1:0] gp_oe,
  input  wire logic [1:0] gp_ext,
  output logic      [1:0] gp_pin
);
  // A released pin rests at its internal pull unless a board resistor overrides it
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      strap_pin[i] = strap_oe[i] ? strap_drv[i] : (pspm_pkg::STRAP_RESET[i] ^ fitted[i]);
    end
  end
  assign gp_pin = (gp_oe & gp_drv) | (~gp_oe & gp_ext);
endmodule : pspm_far_side

// File: dv/tb_top.sv
// Self-checking testbench for the strap pin multiplexer
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = '0, rst = '1, master_reset_in = '1, strap_wr = '0;
  logic uart_tx_a = '0, uart_tx_b = '0, uart_dtr_a = '0, uart_dtr_b = '0;
  logic uart_rts_a = '0, uart_rts_b = '0, irq_a_src = '0, irq_b_src = '0;
  logic clear_to_send_a_n = '1, data_set_ready_a_n = '1;
  logic carrier_detect_a_n = '1, ring_indicator_a_n = '1;
  logic game_rd_n = '1, game_wr_n = '1, dma_a_req = '0, game_ack_n_in = '1;
  logic chip_select_n = '1, io_cycle_n = '1, epp_mode = '0, epp_busy = '0;
  logic dma_active = '0, terminal_count = '0;
  logic [4:0] strap_wdata = '0, fitted = '0, strap_config_register, prev;
  logic [1:0] gpio_out = '0, gpio_oe = '0, gp_ext = '0, gpio_in, gpin;
  logic [7:0] handshake_status_a;
  logic serial_out_a, serial_out_a_oe, serial_out_b, serial_out_b_oe, terminal_ready_b_n;
  logic terminal_ready_a_n, terminal_ready_a_n_oe, send_request_a_n, send_request_a_n_oe;
  logic send_request_b_n, send_request_b_n_oe, gp_io_one, gp_io_one_oe, gp_io_zero;
  logic gp_io_zero_oe, game_pin_rd, game_pin_wr, dma_a_ack, host_select;
  logic channel_ready_oe, dma_done;
  logic [4:0] pin_oe;
  wire  serial_out_a_in, serial_out_b_in, terminal_ready_a_n_in, send_request_a_n_in;
  wire  send_request_b_n_in, gp_io_one_in, gp_io_zero_in;
  wire  [4:0] spin;
  int   n_fail = 0, cmp_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  pspm_strap_mux dut (.*);
  pspm_far_side far (
    .strap_drv ({send_request_b_n, serial_out_b, send_request_a_n, serial_out_a,
                 terminal_ready_a_n}),
    .strap_oe  ({send_request_b_n_oe, serial_out_b_oe, send_request_a_n_oe, serial_out_a_oe,
                 terminal_ready_a_n_oe}),
    .fitted    (fitted),
    .strap_pin (spin),
    .gp_drv    ({gp_io_one, gp_io_zero}),
    .gp_oe     ({gp_io_one_oe, gp_io_zero_oe}),
    .gp_ext    (gp_ext),
    .gp_pin    (gpin)
  );
  assign {send_request_b_n_in, serial_out_b_in, send_request_a_n_in, serial_out_a_in,
          terminal_ready_a_n_in} = spin;
  assign {gp_io_one_in, gp_io_zero_in} = gpin;
  assign pin_oe = {serial_out_a_oe, serial_out_b_oe, terminal_ready_a_n_oe,
                   send_request_a_n_oe, send_request_b_n_oe};

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic sw_write(input logic [4:0] v);
    @(posedge ref_clk);
    strap_wr    <= 1'b1;
    strap_wdata <= v;
    @(posedge ref_clk);
    strap_wr <= 1'b0;
    settle;
  endtask : sw_write

  // Master reset pulse with a board strap set; a write during reset must not land
  task automatic mr_pulse(input logic [4:0] fit);
    prev = strap_config_register;
    @(posedge ref_clk);
    fitted          <= fit;
    master_reset_in <= 1'b1;
    // Host cycle, EPP stretch and terminal count all active: master reset must mask them
    {chip_select_n, io_cycle_n, epp_mode, epp_busy, dma_active, terminal_count} <= 6'h0f;
    settle;
    sw_write(~prev);
    check(8'(strap_config_register), 8'(prev));
    check(handshake_status_a, 8'h00);
    check(8'({host_select, channel_ready_oe, dma_done}), 8'h00);
    check(8'(pin_oe), 8'h00);
    @(posedge ref_clk);
    master_reset_in <= 1'b0;
    settle;
    check(8'(strap_config_register), 8'(pspm_pkg::STRAP_RESET ^ fit));
    check(8'(pin_oe), 8'h1f);
  endtask : mr_pulse

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    report_and_stop;
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    settle;
    check(8'(strap_config_register), 8'(pspm_pkg::STRAP_RESET));
    @(posedge ref_clk);
    clear_to_send_a_n <= 1'b0;
    foreach (prev[i]) mr_pulse(5'h1f >> i);
    mr_pulse(5'h0a);
    $display("test strap capture done");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {ring_indicator_a_n, carrier_detect_a_n, data_set_ready_a_n, clear_to_send_a_n} <=
        ~(4'h1 << i);
      settle;
      check(handshake_status_a, 8'h10 << i);
    end
    $display("test modem inputs done");
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      {uart_dtr_a, uart_dtr_b, uart_rts_a, uart_rts_b, uart_tx_a} <= {5{v[0]}};
      uart_tx_b <= ~v[0];
      settle;
      check(8'({terminal_ready_a_n, terminal_ready_b_n, send_request_a_n, send_request_b_n,
                serial_out_a, serial_out_b}), 8'({{4{~v[0]}}, v[0], ~v[0]}));
    end
    $display("test modem outputs done");
    sw_write(5'h00);
    check(8'(strap_config_register), 8'h00);
    @(posedge ref_clk);
    {irq_a_src, irq_b_src, dma_a_req, game_ack_n_in} <= 4'b1010;
    settle;
    check(8'({gp_io_one_oe, gp_io_zero_oe, gp_io_one, gp_io_zero,
              game_pin_rd, game_pin_wr, dma_a_ack}), 8'h77);
    sw_write(5'h18);
    @(posedge ref_clk);
    {gpio_oe, gpio_out, gp_ext, game_rd_n} <= 7'b0101100;
    settle;
    check(8'({gp_io_one_oe, gp_io_zero_oe, gp_io_zero, gpio_in}), 8'h0f);
    check(8'({game_pin_rd, game_pin_wr, dma_a_ack}), 8'h02);
    $display("test pin functions done");
    // Bit 2 of the step turns EPP mode off; a stretch needs a selected host cycle
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {chip_select_n, io_cycle_n} <= i[1:0];
      {epp_mode, epp_busy} <= {~i[2], 1'b1};
      {dma_active, terminal_count} <= i[1:0];
      settle;
      check(8'({host_select, channel_ready_oe, dma_done}),
            8'({i[1:0] == 2'd0, i == 0, i[1:0] == 2'd3}));
    end
    $display("test host controls done");
    report_and_stop;
  end
endmodule : tb_top
